// [hw/relay_board_safety_watchdog.sv]
`timescale 1ns/100ps
// How it works
// - thirty seconds steady heartbeat kills valves, heat, uv
// - trip leaves sample pump drive alone
// - heater indicators lit exactly while heating
// - zero/span indicator lit on span path
// - sample/cal indicator lit on cal path
// - outputs held predefined until software takes control
// - commands arrive from host over bridged bus
module relay_board_safety_watchdog #(
	parameter int TICK_CYCLES = wdog_pkg::TICK_CYCLES,
	parameter int TIMEOUT_TICKS = wdog_pkg::HB_TIMEOUT_TICKS
) (
	// clock and reset
	input logic clk,
	input logic rstn,
	// register port from the serial bus bridge
	input logic [wdog_pkg::ADDR_W-1:0] addr,
	input logic [wdog_pkg::DATA_W-1:0] wdata,
	input logic wr,
	input logic rd,
	output logic [wdog_pkg::DATA_W-1:0] rdata,
	// interrupt
	output logic irq,
	// heartbeat indicator drive and its sensed level
	output logic heartbeat_indicator,
	input logic heartbeat_sense,
	// power drives
	output logic sample_chamber_zone_heater,
	output logic perm_tube_heater,
	output logic uv_source_on,
	output logic sample_pump_on,
	// valve drivers
	output logic zero_span_valve,
	output logic sample_cal_valve,
	output logic uv_shutter_open,
	output logic [7:0] aux_valves,
	// indicators
	output logic led_sample_chamber_zone,
	output logic led_perm_tube,
	output logic led_zero_span,
	output logic led_sample_cal,
	output logic led_shutter,
	// power-up hold of the neighbouring circuits
	output logic analog_out_hold,
	output logic ext_dio_hold,
	output logic serial_bus_hold
);
	// software-visible registers
	logic [7:0] ctrl_r; // heartbeat and takeover bits
	logic [7:0] drive_r; // heater, valve and pump commands
	logic [7:0] valve_r; // extra valve driver channels
	logic [wdog_pkg::EV_W-1:0] irq_stat_r; // sticky events
	logic [wdog_pkg::EV_W-1:0] irq_en_r; // event mask
	logic [wdog_pkg::EV_W-1:0] ev; // this cycle's events
	logic [wdog_pkg::EV_W-1:0] clr; // this cycle's clears

	// supervisor
	wdog_pkg::sup_state_e state_r;
	wdog_pkg::sup_state_e state_nxt;

	// heartbeat observation
	logic beat_lvl; // cleaned sensed level
	logic beat_prev_r; // level one cycle back
	logic beat_edge; // any transition seen
	logic timed_out; // silence reached the limit

	// effective command after hold and trip gating
	logic [7:0] drive_eff;
	logic [7:0] valve_eff;

	// decoded strobes
	logic wr_ctrl;
	logic wr_drive;
	logic wr_valve;
	logic wr_en;
	logic wr_clr;

	assign wr_ctrl = wr && (addr == wdog_pkg::CTRL_OFS);
	assign wr_drive = wr && (addr == wdog_pkg::DRIVE_OFS);
	assign wr_valve = wr && (addr == wdog_pkg::VALVE_OFS);
	assign wr_en = wr && (addr == wdog_pkg::IRQ_EN_OFS);
	assign wr_clr = wr && (addr == wdog_pkg::IRQ_CLR_OFS);

	// command registers, written by the host through the bridge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_r <= wdog_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= wdata;
		end
	end

	// drive commands; takes effect only once software is live
	always_ff @(posedge clk) begin
		if (!rstn) begin
			drive_r <= wdog_pkg::DRIVE_RST;
		end else if (wr_drive) begin
			drive_r <= wdata;
		end
	end

	// extra valve channels
	always_ff @(posedge clk) begin
		if (!rstn) begin
			valve_r <= wdog_pkg::VALVE_RST;
		end else if (wr_valve) begin
			valve_r <= wdata;
		end
	end

	// interrupt mask
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_en_r <= wdog_pkg::IRQ_EN_RST;
		end else if (wr_en) begin
			irq_en_r <= wdata[wdog_pkg::EV_W-1:0];
		end
	end

	// the indicator pin follows the software bit directly
	assign heartbeat_indicator = ctrl_r[wdog_pkg::CTRL_BEAT];

	// sense the indicator node itself, not the register, so a dead
	// driver or broken bus is caught as well as a dead processor
	pin_sync u_beat_sync (
		.clk(clk),
		.rstn(rstn),
		.pin(heartbeat_sense),
		.level(beat_lvl)
	);

	// edge detect on the cleaned level
	always_ff @(posedge clk) begin
		if (!rstn) begin
			beat_prev_r <= 1'b0;
		end else begin
			beat_prev_r <= beat_lvl;
		end
	end

	assign beat_edge = beat_lvl ^ beat_prev_r;

	// silence timer; armed only while live, so a slow boot cannot trip
	beat_timer #(
		.TICK_CYCLES(TICK_CYCLES),
		.TIMEOUT_TICKS(TIMEOUT_TICKS)
	) u_timer (
		.clk(clk),
		.rstn(rstn),
		.arm(state_r == wdog_pkg::ST_LIVE),
		.restart(beat_edge),
		.expired(timed_out)
	);

	// supervisor next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			wdog_pkg::ST_BOOT: begin
				// hold until software says it has control
				if (ctrl_r[wdog_pkg::CTRL_TAKE]) begin
					state_nxt = wdog_pkg::ST_LIVE;
				end
			end
			wdog_pkg::ST_LIVE: begin
				// steady indicator for the full window
				if (timed_out) begin
					state_nxt = wdog_pkg::ST_SHUT;
				end
			end
			wdog_pkg::ST_SHUT: begin
				// only reset leaves shutdown
				state_nxt = wdog_pkg::ST_SHUT;
			end
			default: begin
				// unknown code: fail safe
				state_nxt = wdog_pkg::ST_SHUT;
			end
		endcase
	end

	// supervisor state register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_r <= wdog_pkg::ST_BOOT;
		end else begin
			state_r <= state_nxt;
		end
	end

	// gating of the commands by supervisor state
	always_comb begin
		drive_eff = drive_r;
		valve_eff = valve_r;
		case (state_r)
			wdog_pkg::ST_BOOT: begin
				// predefined values until takeover
				drive_eff = wdog_pkg::DRIVE_HOLD_VAL;
				valve_eff = wdog_pkg::VALVE_HOLD_VAL;
			end
			wdog_pkg::ST_LIVE: begin
				// commands pass straight through
				drive_eff = drive_r;
				valve_eff = valve_r;
			end
			wdog_pkg::ST_SHUT: begin
				// everything off, then let the pump through
				drive_eff = 8'h00;
				valve_eff = 8'h00;
				drive_eff[wdog_pkg::DRV_PUMP] = drive_r[wdog_pkg::DRV_PUMP];
			end
			default: begin
				drive_eff = 8'h00;
				valve_eff = 8'h00;
			end
		endcase
	end

	// power drives, registered
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sample_chamber_zone_heater <= 1'b0;
			perm_tube_heater <= 1'b0;
			uv_source_on <= 1'b0;
			sample_pump_on <= 1'b0;
		end else begin
			sample_chamber_zone_heater <= drive_eff[wdog_pkg::DRV_CELL_HTR];
			perm_tube_heater <= drive_eff[wdog_pkg::DRV_PERM_HTR];
			uv_source_on <= drive_eff[wdog_pkg::DRV_UV_SRC];
			sample_pump_on <= drive_eff[wdog_pkg::DRV_PUMP];
		end
	end

	// valve drivers, registered; shutter follows its own drive bit, not the lamp
	always_ff @(posedge clk) begin
		if (!rstn) begin
			zero_span_valve <= 1'b0;
			sample_cal_valve <= 1'b0;
			uv_shutter_open <= 1'b0;
			aux_valves <= 8'h00;
		end else begin
			zero_span_valve <= drive_eff[wdog_pkg::DRV_ZS_VALVE];
			sample_cal_valve <= drive_eff[wdog_pkg::DRV_SC_VALVE];
			uv_shutter_open <= drive_eff[wdog_pkg::DRV_SHUTTER];
			aux_valves <= valve_eff;
		end
	end

	// indicators mirror the actual drives, so they go dark on a trip
	always_ff @(posedge clk) begin
		if (!rstn) begin
			led_sample_chamber_zone <= 1'b0;
			led_perm_tube <= 1'b0;
			led_zero_span <= 1'b0;
			led_sample_cal <= 1'b0;
			led_shutter <= 1'b0;
		end else begin
			led_sample_chamber_zone <= drive_eff[wdog_pkg::DRV_CELL_HTR];
			led_perm_tube <= drive_eff[wdog_pkg::DRV_PERM_HTR];
			led_zero_span <= drive_eff[wdog_pkg::DRV_ZS_VALVE];
			led_sample_cal <= drive_eff[wdog_pkg::DRV_SC_VALVE];
			led_shutter <= drive_eff[wdog_pkg::DRV_SHUTTER];
		end
	end

	// hold lines for analog outputs, external i/o and serial bus
	always_ff @(posedge clk) begin
		if (!rstn) begin
			analog_out_hold <= 1'b1;
			ext_dio_hold <= 1'b1;
			serial_bus_hold <= 1'b1;
		end else begin
			analog_out_hold <= (state_nxt == wdog_pkg::ST_BOOT);
			ext_dio_hold <= (state_nxt == wdog_pkg::ST_BOOT);
			serial_bus_hold <= (state_nxt == wdog_pkg::ST_BOOT);
		end
	end

	// events: one-cycle pulses
	always_comb begin
		ev = '0;
		ev[wdog_pkg::EV_TRIP] = (state_r == wdog_pkg::ST_LIVE) && timed_out;
		ev[wdog_pkg::EV_TAKE] = (state_r == wdog_pkg::ST_BOOT) &&
			ctrl_r[wdog_pkg::CTRL_TAKE];
		ev[wdog_pkg::EV_BEAT] = beat_edge;
	end

	assign clr = wr_clr ? wdata[wdog_pkg::EV_W-1:0] : '0;

	// sticky status; a new event beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~clr) | ev;
		end
	end

	// level interrupt while any enabled event is pending
	assign irq = |(irq_stat_r & irq_en_r);

	// read data, valid the cycle after the strobe only
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
				wdog_pkg::CTRL_OFS: begin
					rdata <= ctrl_r;
				end
				wdog_pkg::DRIVE_OFS: begin
					rdata <= drive_r;
				end
				wdog_pkg::VALVE_OFS: begin
					rdata <= valve_r;
				end
				wdog_pkg::STAT_OFS: begin
					rdata <= {4'h0, beat_lvl,
						state_r == wdog_pkg::ST_SHUT,
						state_r == wdog_pkg::ST_LIVE,
						state_r == wdog_pkg::ST_BOOT};
				end
				wdog_pkg::IRQ_STAT_OFS: begin
					rdata <= {5'h00, irq_stat_r};
				end
				wdog_pkg::IRQ_EN_OFS: begin
					rdata <= {5'h00, irq_en_r};
				end
				default: begin
					// clear register and unmapped offsets read zero
					rdata <= 8'h00;
				end
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule

// [hw/wdog_pkg.sv]
package wdog_pkg;
	// register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// register offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] DRIVE_OFS = 8'h04;
	localparam logic [7:0] VALVE_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0c;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
	localparam logic [7:0] IRQ_EN_OFS = 8'h14;
	localparam logic [7:0] IRQ_CLR_OFS = 8'h18;
	// control register fields
	localparam int CTRL_BEAT = 0;
	localparam int CTRL_TAKE = 1;
	// drive register fields
	localparam int DRV_CELL_HTR = 0;
	localparam int DRV_PERM_HTR = 1;
	localparam int DRV_ZS_VALVE = 2;
	localparam int DRV_SC_VALVE = 3;
	localparam int DRV_UV_SRC = 4;
	localparam int DRV_SHUTTER = 5;
	localparam int DRV_PUMP = 6;
	// status register fields
	localparam int ST_HOLD = 0;
	localparam int ST_RUN = 1;
	localparam int ST_TRIP = 2;
	localparam int ST_BEAT = 3;
	// interrupt event fields
	localparam int EV_TRIP = 0;
	localparam int EV_TAKE = 1;
	localparam int EV_BEAT = 2;
	localparam int EV_W = 3;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DRIVE_RST = 8'h00;
	localparam logic [7:0] VALVE_RST = 8'h00;
	localparam logic [2:0] IRQ_EN_RST = 3'h0;
	// predefined outputs while software has not taken over
	localparam logic [7:0] DRIVE_HOLD_VAL = 8'h00;
	localparam logic [7:0] VALVE_HOLD_VAL = 8'h00;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = (TICK_US * 1000) / CLK_PERIOD_NS;
	localparam int HB_PERIOD_S = 3;
	localparam int HB_TIMEOUT_S = 30;
	localparam int HB_TIMEOUT_TICKS = (HB_TIMEOUT_S * 1000000) / TICK_US;
	// supervisor states, gray along boot -> run -> trip
	typedef enum logic [1:0] {
		ST_BOOT = 2'b00,
		ST_LIVE = 2'b01,
		ST_SHUT = 2'b11
	} sup_state_e;
endpackage

// [hw/pin_sync.sv]
`timescale 1ns/100ps
module pin_sync (
	// clock and reset
	input logic clk,
	input logic rstn,
	// pin side
	input logic pin,
	// clean level
	output logic level
);
	logic s1_r; // metastable stage, read only by s2_r
	logic s2_r;
	logic s3_r;

	// three-stage chain
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// a change counts only when stages two and three agree
	always_ff @(posedge clk) begin
		if (!rstn) begin
			level <= 1'b0;
		end else if (s2_r == s3_r) begin
			level <= s3_r;
		end
	end
endmodule

// [hw/beat_timer.sv]
`timescale 1ns/100ps
module beat_timer #(
	parameter int TICK_CYCLES = wdog_pkg::TICK_CYCLES,
	parameter int TIMEOUT_TICKS = wdog_pkg::HB_TIMEOUT_TICKS
) (
	// clock and reset
	input logic clk,
	input logic rstn,
	// control
	input logic arm,
	input logic restart,
	// result
	output logic expired
);
	logic [17:0] pre_r; // prescaler toward one tick
	logic tick; // one-cycle slow enable
	logic [15:0] cnt_r; // ticks of silence

	assign tick = (pre_r == 18'(TICK_CYCLES - 1));

	// prescaler, restarted with the count so timeouts never come early
	always_ff @(posedge clk) begin
		if (!rstn || restart || !arm) begin
			pre_r <= 18'h0;
		end else if (tick) begin
			pre_r <= 18'h0;
		end else begin
			pre_r <= pre_r + 18'h1;
		end
	end

	// silence counter, saturates at the limit
	always_ff @(posedge clk) begin
		if (!rstn || restart || !arm) begin
			cnt_r <= 16'h0;
		end else if (tick && !expired) begin
			cnt_r <= cnt_r + 16'h1;
		end
	end

	assign expired = arm && (cnt_r == 16'(TIMEOUT_TICKS));
endmodule

// [verif/wdog_checker.sv]
`timescale 1ns/100ps
// passive watch on the watchdog pins
module wdog_checker #(
	parameter int TICK_CYCLES = 4,
	parameter int TIMEOUT_TICKS = 5
) (
	// clock and reset
	input logic clk,
	input logic rstn,
	// register writes
	input logic [7:0] addr,
	input logic [7:0] wdata,
	input logic wr,
	// heartbeat and drives
	input logic heartbeat_sense,
	input logic sample_chamber_zone_heater,
	input logic perm_tube_heater,
	input logic uv_source_on,
	input logic sample_pump_on,
	input logic zero_span_valve,
	input logic sample_cal_valve,
	input logic uv_shutter_open,
	input logic [7:0] aux_valves,
	// indicators and holds
	input logic led_sample_chamber_zone,
	input logic led_perm_tube,
	input logic led_zero_span,
	input logic led_sample_cal,
	input logic analog_out_hold,
	input logic ext_dio_hold,
	input logic serial_bus_hold
);
	// wide on purpose: the full-size tick and timeout overflow an int product
	localparam longint LIM = longint'(TICK_CYCLES) * TIMEOUT_TICKS;
	logic [15:0] quiet_r; // cycles since the sensed beat last moved
	logic sense_r;
	logic maybe_r; // a trip may have happened
	logic sure_r; // a trip must have happened
	logic safe_off;
	assign safe_off = !(sample_chamber_zone_heater | perm_tube_heater | uv_source_on |
		zero_span_valve | sample_cal_valve | uv_shutter_open | (|aux_valves));
	// quiet time; zero while held, since the timer is not armed then
	always_ff @(posedge clk) begin
		sense_r <= heartbeat_sense;
		if (!rstn || analog_out_hold || heartbeat_sense != sense_r) begin
			quiet_r <= 16'h0;
		end else if (quiet_r != 16'hffff) begin
			quiet_r <= quiet_r + 16'h1;
		end
	end
	// margins absorb synchroniser lag and tick phase
	always_ff @(posedge clk) begin
		if (!rstn) begin
			maybe_r <= 1'b0;
			sure_r <= 1'b0;
		end else begin
			if (quiet_r >= LIM - 4) maybe_r <= 1'b1;
			if (quiet_r >= LIM + 12) sure_r <= 1'b1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// a drive write out of boot hold, then its landing two edges on
	sequence drive_wr;
		wr && addr == wdog_pkg::DRIVE_OFS && !analog_out_hold;
	endsequence
	sequence pump_lands;
		##2 sample_pump_on == $past(wdata[wdog_pkg::DRV_PUMP], 2);
	endsequence
	sequence heat_lands;
		##2 (maybe_r ||
			sample_chamber_zone_heater == $past(wdata[wdog_pkg::DRV_CELL_HTR], 2));
	endsequence
	chk_trip_off: assert property (sure_r |-> safe_off)
		else $error("drives on after steady beat");
	chk_pump_pass: assert property (drive_wr |-> pump_lands)
		else $error("pump does not follow its command");
	chk_heat_follow: assert property (drive_wr and !maybe_r |-> heat_lands)
		else $error("heater does not follow its command");
	chk_led_heat: assert property (led_sample_chamber_zone == sample_chamber_zone_heater &&
		led_perm_tube == perm_tube_heater)
		else $error("heater led differs from heater");
	chk_led_zs: assert property (led_zero_span == zero_span_valve)
		else $error("zero span led differs from valve");
	chk_led_sc: assert property (led_sample_cal == sample_cal_valve)
		else $error("sample cal led differs from valve");
	chk_hold_off: assert property (analog_out_hold |-> safe_off && !sample_pump_on)
		else $error("drive active in boot hold");
	chk_hold_group: assert property (analog_out_hold == ext_dio_hold &&
		analog_out_hold == serial_bus_hold)
		else $error("hold outputs disagree");
	chk_hold_once: assert property (!$past(analog_out_hold) |-> !analog_out_hold)
		else $error("hold came back without reset");
endmodule
bind relay_board_safety_watchdog wdog_checker #(.TICK_CYCLES(TICK_CYCLES),
	.TIMEOUT_TICKS(TIMEOUT_TICKS)) chk (.clk, .rstn, .addr, .wdata, .wr, .heartbeat_sense,
	.sample_chamber_zone_heater, .perm_tube_heater, .uv_source_on, .sample_pump_on,
	.zero_span_valve, .sample_cal_valve, .uv_shutter_open, .aux_valves,
	.led_sample_chamber_zone, .led_perm_tube, .led_zero_span, .led_sample_cal,
	.analog_out_hold, .ext_dio_hold, .serial_bus_hold);

// [verif/beat_node.sv]
`timescale 1ns/100ps
// host end of the indicator node; a hung host freezes it
module beat_node (
	// clock
	input logic clk,
	// indicator drive and fault control
	input logic heartbeat_indicator,
	input logic stuck,
	// sensed node level
	output logic heartbeat_sense
);
	// frozen node keeps its last level, as a stalled processor would
	always_ff @(posedge clk) begin
		if (!stuck) heartbeat_sense <= heartbeat_indicator;
	end
endmodule

// [verif/testbench.sv]
`timescale 1ns/100ps
module testbench;
	localparam int TK = 4; // shortened tick
	localparam int TO = 5; // shortened timeout in ticks
	localparam int LIM = TK * TO;
	typedef struct packed {
		logic [7:0] wv; // drive value
		logic [7:0] led; // expected indicators
	} row_s;
	// uv and pump have no indicator
	row_s rows [9] = '{'{8'h01, 8'h01}, '{8'h02, 8'h02}, '{8'h04, 8'h04}, '{8'h08, 8'h08},
		'{8'h10, 8'h00}, '{8'h20, 8'h10}, '{8'h40, 8'h00}, '{8'h7f, 8'h1f}, '{8'h00, 8'h00}};
	logic clk, rstn, wr, rd, irq, heartbeat_indicator, heartbeat_sense, stuck;
	logic [7:0] addr, wdata, rdata, aux_valves, ctrl_v;
	logic sample_chamber_zone_heater, perm_tube_heater, uv_source_on, sample_pump_on;
	logic zero_span_valve, sample_cal_valve, uv_shutter_open, led_shutter;
	logic led_sample_chamber_zone, led_perm_tube, led_zero_span, led_sample_cal;
	logic analog_out_hold, ext_dio_hold, serial_bus_hold;
	logic [7:0] drv_seen, led_seen, misc_seen;
	int err_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	assign drv_seen = {1'b0, sample_pump_on, uv_shutter_open, uv_source_on, sample_cal_valve,
		zero_span_valve, perm_tube_heater, sample_chamber_zone_heater};
	assign led_seen = {3'h0, led_shutter, led_sample_cal, led_zero_span, led_perm_tube,
		led_sample_chamber_zone};
	assign misc_seen = {4'h0, irq, analog_out_hold, ext_dio_hold, serial_bus_hold};
	relay_board_safety_watchdog #(.TICK_CYCLES(TK), .TIMEOUT_TICKS(TO)) dut (.clk, .rstn,
		.addr, .wdata, .wr, .rd, .rdata, .irq, .heartbeat_indicator, .heartbeat_sense,
		.sample_chamber_zone_heater, .perm_tube_heater, .uv_source_on, .sample_pump_on,
		.zero_span_valve, .sample_cal_valve, .uv_shutter_open, .aux_valves,
		.led_sample_chamber_zone, .led_perm_tube, .led_zero_span, .led_sample_cal,
		.led_shutter, .analog_out_hold, .ext_dio_hold, .serial_bus_hold);
	beat_node node (.clk, .heartbeat_indicator, .stuck, .heartbeat_sense);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// hang guard, well above the run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk_out(logic [7:0] g, logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t pins %h expected %h", $time, g, e);
		end
	endtask
	// read strobe one cycle; data stand in the next cycle only
	task automatic chk_reg(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		samples_checked++;
		if (rdata !== e) begin
			err_count++;
			$display("[ERR] %0t reg %h read %h expected %h", $time, a, rdata, e);
		end
	endtask
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic beat();
		ctrl_v[wdog_pkg::CTRL_BEAT] = ~ctrl_v[wdog_pkg::CTRL_BEAT];
		wr_reg(wdog_pkg::CTRL_OFS, ctrl_v);
	endtask
	task automatic idle(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	initial begin
		{rstn, wr, rd, stuck, addr, wdata, ctrl_v} = '0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		idle(1);
		chk_out(misc_seen, 8'h07);
		chk_reg(wdog_pkg::CTRL_OFS, wdog_pkg::CTRL_RST);
		chk_reg(wdog_pkg::VALVE_OFS, wdog_pkg::VALVE_RST);
		chk_reg(wdog_pkg::IRQ_EN_OFS, {5'h0, wdog_pkg::IRQ_EN_RST});
		chk_reg(8'h40, 8'h00);
		// commands store in boot hold but stay off the pins
		wr_reg(wdog_pkg::DRIVE_OFS, 8'h7f);
		idle(3);
		chk_out(drv_seen, 8'h00);
		chk_reg(wdog_pkg::DRIVE_OFS, 8'h7f);
		chk_reg(wdog_pkg::STAT_OFS, 8'h01);
		$display("test boot done");
		wr_reg(wdog_pkg::IRQ_EN_OFS, 8'h02);
		ctrl_v = 8'h02;
		wr_reg(wdog_pkg::CTRL_OFS, ctrl_v);
		idle(2);
		chk_out(drv_seen, 8'h7f);
		chk_out(misc_seen, 8'h08);
		beat();
		idle(4);
		// beat event set but masked, so clearing takeover drops irq
		wr_reg(wdog_pkg::IRQ_CLR_OFS, 8'h02);
		idle(1);
		chk_out(misc_seen, 8'h00);
		chk_reg(wdog_pkg::IRQ_STAT_OFS, 8'h04);
		$display("test takeover done");
		foreach (rows[i]) begin
			beat();
			wr_reg(wdog_pkg::DRIVE_OFS, rows[i].wv);
			idle(2);
			chk_out(drv_seen, rows[i].wv);
			chk_out(led_seen, rows[i].led);
		end
		wr_reg(wdog_pkg::VALVE_OFS, 8'ha5);
		idle(2);
		chk_out(aux_valves, 8'ha5);
		$display("test table done");
		// beats spaced under the limit, run well past it
		wr_reg(wdog_pkg::DRIVE_OFS, 8'h7f);
		repeat (5) begin
			beat();
			idle(LIM - 8);
		end
		chk_out(drv_seen, 8'h7f);
		wr_reg(wdog_pkg::IRQ_EN_OFS, 8'h01);
		stuck <= 1'b1;
		idle(LIM + 20);
		chk_out(drv_seen, 8'h40);
		chk_out(aux_valves, 8'h00);
		chk_out(misc_seen, 8'h08);
		stuck <= 1'b0;
		beat();
		beat();
		wr_reg(wdog_pkg::DRIVE_OFS, 8'h3f);
		idle(2);
		chk_out(drv_seen, 8'h00);
		// indicator pin still follows software after a trip
		chk_out({7'h00, heartbeat_indicator}, {7'h00, ctrl_v[wdog_pkg::CTRL_BEAT]});
		// tripped flag stays up although beats came back
		chk_reg(wdog_pkg::STAT_OFS, {4'h0, ctrl_v[wdog_pkg::CTRL_BEAT], 3'b100});
		$display("test trip done");
		@(posedge clk);
		rstn <= 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		idle(1);
		chk_out(misc_seen, 8'h07);
		chk_out(drv_seen, 8'h00);
		$display("test reset done");
		close_out();
	end
endmodule
